// [dqv_ctrl_model.sv]
/*
 * Behavioural memory controller that issues mode register commands.
 * Assumes the core clock paces it; the memory clock stays low between frames.
 */
`timescale 1ns/100ps
module dqv_ctrl_model
    import dqv_pkg::*;
(
    // Pacing clock
    input  wire logic            i_core_clk,
    // Command pins
    output logic                 o_mem_ck,
    output logic                 o_cmd_mrw,
    output logic                 o_cmd_mrr,
    output logic                 o_cmd_cal_read,
    output logic [MA_W-1:0]      o_cmd_ma,
    output logic [OP_W-1:0]      o_cmd_op
);
    initial begin
        {o_mem_ck, o_cmd_mrw, o_cmd_mrr, o_cmd_cal_read, o_cmd_ma, o_cmd_op} = '0;
    end

    // One frame per call; back-to-back calls give consecutive rises 80 ns apart
    task automatic issue(input logic [2:0] kind, input logic [MA_W-1:0] ma,
                         input logic [OP_W-1:0] op);
        @(posedge i_core_clk);
        #1;
        {o_cmd_mrw, o_cmd_mrr, o_cmd_cal_read} = kind;
        o_cmd_ma = ma;
        o_cmd_op = op; // Level code and range bit travel in one operand
        repeat (10) @(posedge i_core_clk);
        #1;
        o_mem_ck = 1'b1;
        repeat (9) @(posedge i_core_clk);
        #1;
        o_mem_ck = 1'b0;
        // Hold time over: show inverted levels so stale values cannot pass
        {o_cmd_mrw, o_cmd_mrr, o_cmd_cal_read, o_cmd_ma, o_cmd_op} =
            ~{o_cmd_mrw, o_cmd_mrr, o_cmd_cal_read, o_cmd_ma, o_cmd_op};
    endtask
endmodule

// [dqv_pkg.sv]
/*
 * Shared constants for the DQ reference level and calibration invert
 * mode registers: mode register addresses, field positions, reset values.
 * Assumes mode register addresses arrive as 6-bit codes with 8-bit operands.
 */
package dqv_pkg;

    // Mode register addresses reached by write and read commands
    localparam logic [5:0] MR_ADDR_DQ_REF  = 6'h0e;
    localparam logic [5:0] MR_ADDR_CAL_INV = 6'h0f;

    // Reference level register layout
    localparam int         REF_CODE_W     = 6;
    localparam int         REF_ENTRY_W    = 7;
    localparam int         REF_RANGE_BIT  = 6;
    localparam logic [5:0] REF_CODE_MAX   = 6'h32;
    localparam logic [5:0] REF_CODE_RESET = 6'h1d;
    localparam logic       REF_RANGE_RESET = 1'b1;

    // Two frequency set points, one register copy each
    localparam int         SET_POINTS     = 2;

    // Lower-byte calibration invert mask
    localparam int         LANES          = 8;
    localparam logic [7:0] CAL_INV_RESET  = 8'h55;

    // Layout of the synchronised link bundle
    localparam int         OP_W           = 8;
    localparam int         MA_W           = 6;
    localparam int         SYNC_W         = 4 + MA_W + OP_W;
    localparam int         SYNC_CK_BIT    = SYNC_W - 1;
    localparam int         SYNC_MRW_BIT   = SYNC_W - 2;
    localparam int         SYNC_MRR_BIT   = SYNC_W - 3;
    localparam int         SYNC_CAL_BIT   = SYNC_W - 4;
    localparam int         SYNC_MA_LSB    = OP_W;

    typedef enum logic [1:0] {
        DQV_IDLE      = 2'b00,
        DQV_MRR_DRIVE = 2'b01,
        DQV_CAL_DRIVE = 2'b10
    } dqv_state_type;

endpackage

// [dqv_ref_calib_regs.sv]
/*
 * DQ reference level register (one copy per frequency set point) and
 * lower-byte calibration invert mask, with the calibration read path.
 * Assumes commands are sampled on rising edges of the memory clock, which
 * is oversampled by the core clock; set point selects and the pattern bit
 * come from neighbouring logic on the core clock.
 */
// What this block does
// - Level codes 0..50 legal; others reserved.
// - Bit 6 selects reference range.
// - One level copy per frequency set point.
// - Invert mask write-only, bit n lane n.
// - Mask bit one inverts pattern on lane.
// - Invert mask resets to 55 hex.
// - Mask/inversion lane never inverted.
// - No bus inversion during read calibration.
// - Register access hits write-selected copy only.
// - Operate from active set point copy.
// - Read puts register on DQ, zeros elsewhere.
`timescale 1ns/100ps
module dqv_ref_calib_regs
    import dqv_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    // Command link on the memory clock
    input  wire logic                  i_mem_ck,
    input  wire logic                  i_cmd_mrw,
    input  wire logic                  i_cmd_mrr,
    input  wire logic                  i_cmd_cal_read,
    input  wire logic [MA_W-1:0]       i_cmd_ma,
    input  wire logic [OP_W-1:0]       i_cmd_op,
    // Set point selects and calibration pattern
    input  wire logic                  i_write_set_point_select,
    input  wire logic                  i_operating_set_point_select,
    input  wire logic                  i_cal_pattern_bit,
    // Lower-byte data pins
    output logic [LANES-1:0]           o_dq,
    output logic                       o_dq_oe,
    output logic                       o_mask_inversion_lane,
    output logic                       o_mask_inversion_lane_oe,
    // Active receiver reference
    output logic [REF_CODE_W-1:0]      o_dq_receiver_reference,
    output logic                       o_dq_receiver_range
);

    function automatic logic is_legal_code(input logic [REF_CODE_W-1:0] code);
        return code <= REF_CODE_MAX;
    endfunction

    function automatic logic [OP_W-1:0] read_word(input logic [REF_ENTRY_W-1:0] entry);
        return {1'b0, entry};
    endfunction

    dqv_sync_if #(.WIDTH(SYNC_W)) sync_bus ();

    assign sync_bus.raw = {i_mem_ck, i_cmd_mrw, i_cmd_mrr, i_cmd_cal_read, i_cmd_ma, i_cmd_op};

    dqv_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .sync       (sync_bus.sink)
    );

    logic            ck_s;
    logic            mrw_s;
    logic            mrr_s;
    logic            cal_s;
    logic [MA_W-1:0] ma_s;
    logic [OP_W-1:0] op_s;

    assign ck_s  = sync_bus.filt[SYNC_CK_BIT];
    assign mrw_s = sync_bus.filt[SYNC_MRW_BIT];
    assign mrr_s = sync_bus.filt[SYNC_MRR_BIT];
    assign cal_s = sync_bus.filt[SYNC_CAL_BIT];
    assign ma_s  = sync_bus.filt[SYNC_MA_LSB +: MA_W];
    assign op_s  = sync_bus.filt[OP_W-1:0];

    dqv_state_type            state;
    dqv_state_type            next_state;
    logic                     ck_prev;
    logic                     next_ck_prev;
    logic [REF_ENTRY_W-1:0]   ref_copy      [SET_POINTS];
    logic [REF_ENTRY_W-1:0]   next_ref_copy [SET_POINTS];
    logic [LANES-1:0]         inv_mask;
    logic [LANES-1:0]         next_inv_mask;
    logic [LANES-1:0]         next_dq;
    logic                     next_dq_oe;
    logic                     next_lane;
    logic                     next_lane_oe;
    logic [REF_CODE_W-1:0]    next_ref_code;
    logic                     next_ref_range;
    logic                     ck_rise;
    logic                     fire_mrw;
    logic                     fire_mrr;
    logic                     fire_cal;
    logic [REF_ENTRY_W-1:0]   wr_copy;
    logic [REF_ENTRY_W-1:0]   other_copy;
    logic [REF_ENTRY_W-1:0]   act_copy;

    // Command is taken on the filtered memory clock rising edge
    assign ck_rise  = ck_s & ~ck_prev;
    assign fire_mrw = ck_rise & mrw_s;
    assign fire_mrr = ck_rise & ~mrw_s & mrr_s;
    assign fire_cal = ck_rise & ~mrw_s & ~mrr_s & cal_s;

    assign wr_copy    = ref_copy[i_write_set_point_select];
    assign other_copy = ref_copy[~i_write_set_point_select];
    assign act_copy   = ref_copy[i_operating_set_point_select];

    always_comb begin
        next_state     = state;
        next_ck_prev   = ck_s;
        next_ref_copy  = ref_copy;
        next_inv_mask  = inv_mask;
        next_dq        = o_dq;
        next_dq_oe     = o_dq_oe;
        next_lane      = o_mask_inversion_lane;
        next_lane_oe   = o_mask_inversion_lane_oe;
        // Inactive copy may change freely without disturbing the outputs
        next_ref_code  = act_copy[REF_CODE_W-1:0];
        next_ref_range = act_copy[REF_RANGE_BIT];

        // A drive lasts exactly one memory clock period
        case (state)
            DQV_IDLE: begin
            end
            DQV_MRR_DRIVE,
            DQV_CAL_DRIVE: begin
                if (ck_rise) begin
                    next_state   = DQV_IDLE;
                    next_dq      = '0;
                    next_dq_oe   = 1'b0;
                    next_lane    = 1'b0;
                    next_lane_oe = 1'b0;
                end
            end
            default: begin
                next_state = DQV_IDLE;
            end
        endcase

        if (fire_mrw) begin
            if (ma_s == MR_ADDR_DQ_REF) begin
                // Reserved level code drops the whole write, range included
                if (is_legal_code(op_s[REF_CODE_W-1:0])) begin
                    next_ref_copy[i_write_set_point_select] = op_s[REF_ENTRY_W-1:0];
                end
            end else if (ma_s == MR_ADDR_CAL_INV) begin
                next_inv_mask = op_s;
            end
        end else if (fire_mrr) begin
            next_state   = DQV_MRR_DRIVE;
            next_dq_oe   = 1'b1;
            next_lane    = 1'b0;
            next_lane_oe = 1'b1;
            // Write-only mask and unmapped addresses read back as zero
            if (ma_s == MR_ADDR_DQ_REF) begin
                next_dq = read_word(wr_copy);
            end else begin
                next_dq = '0;
            end
        end else if (fire_cal) begin
            next_state   = DQV_CAL_DRIVE;
            next_dq      = {LANES{i_cal_pattern_bit}} ^ inv_mask;
            next_dq_oe   = 1'b1;
            // True pattern here, never bus inversion
            next_lane    = i_cal_pattern_bit;
            next_lane_oe = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state                    <= DQV_IDLE;
            ck_prev                  <= 1'b0;
            ref_copy[0]              <= {REF_RANGE_RESET, REF_CODE_RESET};
            ref_copy[1]              <= {REF_RANGE_RESET, REF_CODE_RESET};
            inv_mask                 <= CAL_INV_RESET;
            o_dq                     <= '0;
            o_dq_oe                  <= 1'b0;
            o_mask_inversion_lane    <= 1'b0;
            o_mask_inversion_lane_oe <= 1'b0;
            o_dq_receiver_reference  <= REF_CODE_RESET;
            o_dq_receiver_range      <= REF_RANGE_RESET;
        end else if (i_ce) begin
            state                    <= next_state;
            ck_prev                  <= next_ck_prev;
            ref_copy                 <= next_ref_copy;
            inv_mask                 <= next_inv_mask;
            o_dq                     <= next_dq;
            o_dq_oe                  <= next_dq_oe;
            o_mask_inversion_lane    <= next_lane;
            o_mask_inversion_lane_oe <= next_lane_oe;
            o_dq_receiver_reference  <= next_ref_code;
            o_dq_receiver_range      <= next_ref_range;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_ref_write;
        i_ce && fire_mrw && ma_s == MR_ADDR_DQ_REF && is_legal_code(op_s[REF_CODE_W-1:0]);
    endsequence

    sequence s_mask_write;
        i_ce && fire_mrw && ma_s == MR_ADDR_CAL_INV;
    endsequence

    sequence s_cal_beat;
        i_ce && fire_cal;
    endsequence

    sequence s_ref_read;
        i_ce && fire_mrr && ma_s == MR_ADDR_DQ_REF;
    endsequence

    a_codes_stay_legal: assert property (
        is_legal_code(ref_copy[0][REF_CODE_W-1:0]) && is_legal_code(ref_copy[1][REF_CODE_W-1:0]))
        else $error("reference copy holds a reserved code");

    a_reset_values: assert property ($rose(i_rst_n) |->
        inv_mask == CAL_INV_RESET && ref_copy[0] == {REF_RANGE_RESET, REF_CODE_RESET}
        && ref_copy[1] == {REF_RANGE_RESET, REF_CODE_RESET})
        else $error("reset values wrong");

    a_write_hits_selected: assert property (s_ref_write |=>
        ref_copy[$past(i_write_set_point_select)] == $past(op_s[REF_ENTRY_W-1:0]))
        else $error("reference write missed selected copy");

    a_other_copy_kept: assert property (s_ref_write |=>
        ref_copy[~$past(i_write_set_point_select)] == $past(other_copy))
        else $error("reference write disturbed other copy");

    a_mask_write_taken: assert property (s_mask_write |=> inv_mask == $past(op_s))
        else $error("invert mask write lost");

    a_cal_lane_invert: assert property (s_cal_beat |=>
        o_dq_oe && o_dq == ({LANES{$past(i_cal_pattern_bit)}} ^ $past(inv_mask)))
        else $error("calibration lane data wrong");

    a_lane_true_pattern: assert property (s_cal_beat |=>
        o_mask_inversion_lane_oe && o_mask_inversion_lane == $past(i_cal_pattern_bit))
        else $error("mask inversion lane not true pattern");

    a_ref_read_data: assert property (s_ref_read |=>
        o_dq_oe && o_dq == read_word($past(wr_copy)) && !o_mask_inversion_lane)
        else $error("reference read data wrong");

    a_active_copy_out: assert property (i_ce |=>
        {o_dq_receiver_range, o_dq_receiver_reference} == $past(act_copy))
        else $error("outputs not from active copy");

    a_drive_released: assert property (state == DQV_IDLE |-> !o_dq_oe && !o_mask_inversion_lane_oe)
        else $error("pins driven while idle");

endmodule

// [dqv_ref_calib_regs_tb.sv]
/*
 * Self-checking bench for the reference level and invert mask registers.
 * Assumes the controller model paces commands on the core clock.
 */
`timescale 1ns/100ps
module dqv_ref_calib_regs_tb
    import dqv_pkg::*;
;
    localparam logic [2:0] K_MRW = 3'h4;
    localparam logic [2:0] K_MRR = 3'h2;
    localparam logic [2:0] K_CAL = 3'h1;
    localparam logic [2:0] K_NOP = 3'h0;

    logic                  i_core_clk;
    logic                  i_rst_n;
    logic                  i_ce;
    logic                  mem_ck;
    logic                  cmd_mrw;
    logic                  cmd_mrr;
    logic                  cmd_cal;
    logic [MA_W-1:0]       cmd_ma;
    logic [OP_W-1:0]       cmd_op;
    logic                  wsel;
    logic                  osel;
    logic                  pat;
    logic [LANES-1:0]      dq;
    logic                  dq_oe;
    logic                  lane;
    logic                  lane_oe;
    logic [REF_CODE_W-1:0] ref_code;
    logic                  ref_range;
    int                    num_errors;
    int                    comparisons;

    dqv_ctrl_model ctrl (
        .i_core_clk     (i_core_clk),
        .o_mem_ck       (mem_ck),
        .o_cmd_mrw      (cmd_mrw),
        .o_cmd_mrr      (cmd_mrr),
        .o_cmd_cal_read (cmd_cal),
        .o_cmd_ma       (cmd_ma),
        .o_cmd_op       (cmd_op)
    );

    dqv_ref_calib_regs uut (
        .i_core_clk                   (i_core_clk),
        .i_rst_n                      (i_rst_n),
        .i_ce                         (i_ce),
        .i_mem_ck                     (mem_ck),
        .i_cmd_mrw                    (cmd_mrw),
        .i_cmd_mrr                    (cmd_mrr),
        .i_cmd_cal_read               (cmd_cal),
        .i_cmd_ma                     (cmd_ma),
        .i_cmd_op                     (cmd_op),
        .i_write_set_point_select     (wsel),
        .i_operating_set_point_select (osel),
        .i_cal_pattern_bit            (pat),
        .o_dq                         (dq),
        .o_dq_oe                      (dq_oe),
        .o_mask_inversion_lane        (lane),
        .o_mask_inversion_lane_oe     (lane_oe),
        .o_dq_receiver_reference      (ref_code),
        .o_dq_receiver_range          (ref_range)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic conclude();
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic setsel(input logic w, input logic o, input logic p);
        @(posedge i_core_clk);
        #1;
        wsel = w;
        osel = o;
        pat = p;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    task automatic ref_chk(input logic [5:0] code, input logic rng);
        chk("reference", {1'b0, rng, code}, {1'b0, ref_range, ref_code});
    endtask

    // Answer stands until the next memory clock rise, then pins are released
    task automatic drive_chk(input logic [2:0] kind, input logic [5:0] ma,
                             input logic [7:0] exp_dq);
        ctrl.issue(kind, ma, 8'h00);
        chk("dq", exp_dq, dq);
        chk("oe", 8'h03, {6'h00, dq_oe, lane_oe});
        chk("lane", {7'h00, (kind == K_CAL) & pat}, {7'h00, lane});
        ctrl.issue(K_NOP, 6'h00, 8'h00);
        chk("dq_idle", 8'h00, dq);
        chk("oe_idle", 8'h00, {6'h00, dq_oe, lane_oe});
    endtask

    task automatic t_reset();
        ref_chk(REF_CODE_RESET, REF_RANGE_RESET);
        drive_chk(K_MRR, MR_ADDR_DQ_REF, 8'h5d);
    endtask

    task automatic t_mask();
        logic [7:0] masks [3] = '{8'h15, 8'h00, 8'hff};
        setsel(1'b0, 1'b0, 1'b1);
        drive_chk(K_CAL, 6'h00, 8'haa);
        foreach (masks[i]) begin
            ctrl.issue(K_MRW, MR_ADDR_CAL_INV, masks[i]);
            drive_chk(K_CAL, 6'h00, ~masks[i]);
        end
        setsel(1'b0, 1'b0, 1'b0);
        // Frozen clock enable must drop a whole frame
        i_ce = 1'b0;
        ctrl.issue(K_MRW, MR_ADDR_CAL_INV, 8'h3c);
        i_ce = 1'b1;
        drive_chk(K_CAL, 6'h00, 8'hff);
        drive_chk(K_MRR, MR_ADDR_CAL_INV, 8'h00);
    endtask

    task automatic t_setpoints();
        setsel(1'b1, 1'b0, 1'b0);
        ctrl.issue(K_MRW, MR_ADDR_DQ_REF, 8'h00);
        ref_chk(REF_CODE_RESET, 1'b1);
        drive_chk(K_MRR, MR_ADDR_DQ_REF, 8'h00);
        setsel(1'b0, 1'b0, 1'b0);
        drive_chk(K_MRR, MR_ADDR_DQ_REF, 8'h5d);
        setsel(1'b1, 1'b1, 1'b0);
        ref_chk(6'h00, 1'b0);
        ctrl.issue(K_MRW, MR_ADDR_DQ_REF, 8'hf2);
        ref_chk(REF_CODE_MAX, 1'b1);
        ctrl.issue(K_MRW, MR_ADDR_DQ_REF, 8'h33);
        ctrl.issue(K_MRW, MR_ADDR_DQ_REF, 8'h3f);
        ref_chk(REF_CODE_MAX, 1'b1);
        drive_chk(K_MRR, MR_ADDR_DQ_REF, 8'h72);
        setsel(1'b1, 1'b0, 1'b0);
        ref_chk(REF_CODE_RESET, 1'b1);
    endtask

    // About 28 frames of 80 ns are expected; allow ample margin
    initial begin
        #20000;
        num_errors++;
        conclude();
    end

    initial begin
        num_errors = 0;
        comparisons = 0;
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        wsel = 1'b0;
        osel = 1'b0;
        pat = 1'b0;
        repeat (6) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1;
        t_reset();
        t_mask();
        t_setpoints();
        conclude();
    end
endmodule

// [dqv_sync.sv]
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes the bundle is asynchronous to i_core_clk; a bit changes only
 * once the second and third stages agree on it.
 */
`timescale 1ns/100ps
module dqv_sync #(
    parameter int WIDTH = 18
) (
    // Clock and reset
    input wire logic    i_core_clk,
    input wire logic    i_rst_n,
    input wire logic    i_ce,
    // Bundle
    dqv_sync_if.sink    sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] next_held;

    // Stage1 feeds stage2 only; the filter sees stages two and three
    always_comb begin
        next_held = (~(stage2 ^ stage3) & stage2) | ((stage2 ^ stage3) & held);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            held   <= '0;
        end else if (i_ce) begin
            stage1 <= sync.raw;
            stage2 <= stage1;
            stage3 <= stage2;
            held   <= next_held;
        end
    end

    assign sync.filt = held;
endmodule

// [dqv_sync_if.sv]
/*
 * Carries a raw bundle of pin levels into the synchroniser and the
 * filtered levels back out. Assumes both ends share the core clock.
 */
`timescale 1ns/100ps
interface dqv_sync_if #(
    parameter int WIDTH = 18
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] filt;

    modport src  (output raw, input  filt);
    modport sink (input  raw, output filt);
endinterface
